// ### hdl/ltx_device.sv
// Function
// R1: rail inputs read per configured rail mode
// R2: single rail: serial data on positive rail
// R3: single rail: B3ZS at DS3/STS-1, HDB3 at E3
// R4: rails captured on transmit clock active edge
// R5: dual rail: positive rail marks positive pulse
// R6: dual rail: negative rail marks negative pulse
// R7: dual rail bypasses encoder, pulses unchanged
// R8: dual rail input arrives already line coded
// R9: single rail ignores negative rail, held low
// R10: positive pulse drives plus above minus
// R11: negative pulse drives plus below minus
// R12: outputs tri-stated when global or channel off
// R13: global pin low powers off every transmitter
// R14: on after power-up; channel bit rules otherwise
// R15: no pulse requested gives zero line level
// R16: both rails asserted gives no pulse
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ltx_device
   import ltx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   ltx_link_if.dev link,
   input wire logic dual_rail_i,
   input wire logic rate_e3_i,
   input wire logic chan_tx_on_i,
   output logic bit_strobe_o,
   output logic invalid_pair_o,
   output logic line_active_o
);
   logic [3:0] raw_in;
   logic [3:0] synced;
   logic clk_s;
   logic pos_s;
   logic neg_s;
   logic gon_s;
   logic clk_d;
   logic bit_tick;
   ltx_sym_t dly [0:3];
   ltx_sym_t next_dly [0:3];
   logic parity;
   logic next_parity;
   ltx_sym_t out_sym;
   logic last_pol;
   logic enc_plus;
   logic enc_minus;
   logic next_last_pol;
   logic pulse_plus;
   logic pulse_minus;
   logic tx_enable;

   // every pin from the far end passes two flip-flops
   assign raw_in = {link.transmitter_on_control, link.tx_negative_rail,
                    link.tx_positive_rail, link.tx_line_clock};

   ltx_sync #(
      .WIDTH(4),
      .RST_VAL(SYNC_RESET)
   ) u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .async_i(raw_in),
      .sync_o(synced)
   );

   assign clk_s = synced[0];
   assign pos_s = synced[1];
   assign neg_s = synced[2];
   assign gon_s = synced[3];

   // rising edge of the transmit clock marks one bit period
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clk_d <= 1'b0;
      end else begin
         clk_d <= clk_s;
      end
   end

   assign bit_tick = clk_s & ~clk_d; // R4

   // encoder: shift in, spot zero runs, substitute pending symbols
   always_comb begin
      next_dly[0] = pos_s ? SYM_MARK : SYM_ZERO; // R2 R9
      next_dly[1] = dly[0];
      next_dly[2] = dly[1];
      next_dly[3] = dly[2];
      next_parity = parity ^ pos_s;
      if (!pos_s && rate_e3_i && dly[0] == SYM_ZERO &&
          dly[1] == SYM_ZERO && dly[2] == SYM_ZERO) begin
         // four zeros: 000V or B00V
         next_dly[0] = SYM_VIOL; // R3
         if (!parity) begin
            next_dly[3] = SYM_BAL; // R3
         end
         next_parity = 1'b0;
      end else if (!pos_s && !rate_e3_i && dly[0] == SYM_ZERO &&
                   dly[1] == SYM_ZERO) begin
         // three zeros: 00V or B0V
         next_dly[0] = SYM_VIOL; // R3
         if (!parity) begin
            next_dly[2] = SYM_BAL; // R3
         end
         next_parity = 1'b0;
      end
   end

   // symbol leaving the line of the active rate's length
   assign out_sym = rate_e3_i ? next_dly[HDB3_RUN-1] : next_dly[B3ZS_RUN-1];

   // delay line and pulse parity since last violation
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < 4; i++) begin
            dly[i] <= SYM_ZERO;
         end
         parity <= 1'b0;
      end else if (dual_rail_i) begin
         // encoder idle while bypassed
         for (int i = 0; i < 4; i++) begin
            dly[i] <= SYM_ZERO; // R7
         end
         parity <= 1'b0;
      end else if (bit_tick) begin
         for (int i = 0; i < 4; i++) begin
            dly[i] <= next_dly[i];
         end
         parity <= next_parity;
      end
   end

   // marks alternate, violations repeat the last polarity
   always_comb begin
      enc_plus = 1'b0;
      enc_minus = 1'b0;
      next_last_pol = last_pol;
      case (out_sym)
         SYM_MARK, SYM_BAL: begin
            next_last_pol = ~last_pol;
            enc_plus = ~last_pol;
            enc_minus = last_pol;
         end
         SYM_VIOL: begin
            enc_plus = last_pol;
            enc_minus = ~last_pol;
         end
         default: begin
            enc_plus = 1'b0; // R15
            enc_minus = 1'b0;
         end
      endcase
   end

   // polarity of the last pulse sent (1 = positive)
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         last_pol <= 1'b0;
      end else if (bit_tick && !dual_rail_i) begin
         last_pol <= next_last_pol;
      end
   end

   // rail mode selects encoded or bypassed pulses
   always_comb begin
      if (dual_rail_i) begin // R1
         pulse_plus = pos_s & ~neg_s; // R5 R7 R8 R16
         pulse_minus = neg_s & ~pos_s; // R6 R7 R8 R16
      end else begin
         pulse_plus = enc_plus; // R1 R3
         pulse_minus = enc_minus;
      end
   end

   // line drive, one bit period per pulse
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link.line_out_plus <= 1'b0;
         link.line_out_minus <= 1'b0;
      end else if (bit_tick) begin
         link.line_out_plus <= pulse_plus; // R10 R11 R15
         link.line_out_minus <= pulse_minus; // R10 R11 R15
      end
   end

   // global pin gates all; channel bit rules while it is high
   assign tx_enable = gon_s & chan_tx_on_i; // R12 R13 R14

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link.line_out_plus_oe <= 1'b1; // R14
         link.line_out_minus_oe <= 1'b1;
      end else begin
         link.line_out_plus_oe <= tx_enable; // R12 R13
         link.line_out_minus_oe <= tx_enable;
      end
   end

   // user-side status
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_strobe_o <= 1'b0;
         invalid_pair_o <= 1'b0;
         line_active_o <= 1'b1;
      end else begin
         bit_strobe_o <= bit_tick;
         invalid_pair_o <= bit_tick & dual_rail_i & pos_s & neg_s; // R16
         line_active_o <= tx_enable;
      end
   end
endmodule
`default_nettype wire

// ### hdl/ltx_pkg.sv
package ltx_pkg;
   // clock figures
   localparam int CLK_PERIOD_NS = 20;
   localparam int LINK_PERIOD_NS = 160;
   localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;

   // zero-run lengths that trigger substitution
   localparam int B3ZS_RUN = 3;
   localparam int HDB3_RUN = 4;

   // host register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DATA = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;

   // control field positions and reset value
   localparam int CTRL_DUAL_BIT = 0;
   localparam int CTRL_TRANSMITTER_ON_CONTROL_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;

   // status field positions
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_LEFT_LSB = 8;

   // bits per data word in each rail mode
   localparam logic [5:0] BITS_SINGLE = 6'h20;
   localparam logic [5:0] BITS_DUAL = 6'h10;

   // synchroniser reset: global on reads high after power-up
   localparam logic [3:0] SYNC_RESET = 4'h8;

   // symbols held in the encoder delay line
   typedef enum logic [1:0] {
      SYM_ZERO = 2'b00,
      SYM_MARK = 2'b01,
      SYM_VIOL = 2'b10,
      SYM_BAL = 2'b11
   } ltx_sym_t;
endpackage

// ### hdl/ltx_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ltx_link_if;
   logic tx_line_clock;
   logic tx_positive_rail;
   logic tx_negative_rail;
   logic transmitter_on_control;
   logic line_out_plus;
   logic line_out_plus_oe;
   logic line_out_minus;
   logic line_out_minus_oe;

   // documented line interface end
   modport dev (
      input tx_line_clock,
      input tx_positive_rail,
      input tx_negative_rail,
      input transmitter_on_control,
      output line_out_plus,
      output line_out_plus_oe,
      output line_out_minus,
      output line_out_minus_oe
   );

   // terminal equipment end
   modport host (
      output tx_line_clock,
      output tx_positive_rail,
      output tx_negative_rail,
      output transmitter_on_control
   );
endinterface
`default_nettype wire

// ### hdl/ltx_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ltx_sync
   import ltx_pkg::*;
#(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   // two-stage synchroniser; only the second stage is visible
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule
`default_nettype wire

// ### hdl/ltx_host.sv
`timescale 1ns/1ps
`default_nettype none
module ltx_host
   import ltx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   ltx_link_if.host link,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o
);
   logic [1:0] ctrl;
   logic [31:0] shift;
   logic [5:0] bits_left;
   logic [7:0] div_cnt;
   logic fall_tick;
   logic access;
   logic busy;
   logic data_wr;
   logic mapped;
   logic accept;
   logic done;
   logic [31:0] rd_val;

   assign busy = (bits_left != 6'h00);
   assign access = psel_i & penable_i & ~pready_o;
   assign data_wr = pwrite_i & (paddr_i == REG_DATA);
   // a data write waits while the shifter still holds a word
   assign accept = access & ~(data_wr & busy);
   // writes land only on the edge where the master sees pready high
   assign done = psel_i & penable_i & pready_o;
   assign mapped = (paddr_i == REG_CTRL) | (paddr_i == REG_DATA) |
                   (paddr_i == REG_STATUS);

   // link clock divider; rails change on its falling edge
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_cnt <= 8'h00;
         link.tx_line_clock <= 1'b0;
      end else if (div_cnt == 8'(LINK_HALF_CYC - 1)) begin
         div_cnt <= 8'h00;
         link.tx_line_clock <= ~link.tx_line_clock;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   assign fall_tick = (div_cnt == 8'(LINK_HALF_CYC - 1)) &
                      link.tx_line_clock;

   // control register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl <= CTRL_RESET;
      end else if (done && pwrite_i && paddr_i == REG_CTRL) begin
         ctrl <= pwdata_i[1:0];
      end
   end

   // serialiser: single rail lsb first, dual pairs bit n with n+16
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         shift <= 32'h0000_0000;
         bits_left <= 6'h00;
      end else if (done && data_wr) begin
         shift <= pwdata_i;
         bits_left <= ctrl[CTRL_DUAL_BIT] ? BITS_DUAL : BITS_SINGLE;
      end else if (fall_tick && busy) begin
         if (ctrl[CTRL_DUAL_BIT]) begin
            // software hands over pairs it has already line coded
            shift <= {1'b0, shift[31:17], 1'b0, shift[15:1]}; // R8
         end else begin
            shift <= {1'b0, shift[31:1]};
         end
         bits_left <= bits_left - 6'h01;
      end
   end

   // rails; negative held low in single rail mode
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link.tx_positive_rail <= 1'b0;
         link.tx_negative_rail <= 1'b0;
      end else if (fall_tick) begin
         link.tx_positive_rail <= busy & shift[0]; // R2 R5
         link.tx_negative_rail <= busy & ctrl[CTRL_DUAL_BIT] & shift[16]; // R6 R9
      end
   end

   // global transmitter-on pin from control
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link.transmitter_on_control <= 1'b1;
      end else begin
         link.transmitter_on_control <= ctrl[CTRL_TRANSMITTER_ON_CONTROL_BIT];
      end
   end

   // read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      case (paddr_i)
         REG_CTRL: rd_val = {30'h0, ctrl};
         REG_STATUS: begin
            rd_val[STAT_BUSY_BIT] = busy;
            rd_val[STAT_LEFT_LSB +: 6] = bits_left;
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // apb answer, registered
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= accept;
         pslverr_o <= accept & ~mapped;
         prdata_o <= (accept && !pwrite_i) ? rd_val : 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// ### verif/ltx_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ltx_link_properties (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic tx_line_clock,
   input wire logic tx_positive_rail,
   input wire logic tx_negative_rail,
   input wire logic transmitter_on_control,
   input wire logic line_out_plus,
   input wire logic line_out_plus_oe,
   input wire logic line_out_minus,
   input wire logic line_out_minus_oe
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // line symbol and drive checks
   pol_exclusive_a: assert property (
      !(line_out_plus && line_out_minus))
      else $error("both line outputs high");
   off_hold_a: assert property ((!transmitter_on_control) [*5] |->
      !line_out_plus_oe && !line_out_minus_oe)
      else $error("line driven while global off");
   off_fell_a: assert property ($fell(transmitter_on_control) |->
      ##[1:5] !line_out_plus_oe)
      else $error("line not released after global off");
   oe_pair_a: assert property (line_out_plus_oe == line_out_minus_oe)
      else $error("line enables differ");
   sym_hold_a: assert property ($changed({line_out_plus, line_out_minus})
      && line_out_plus_oe |=> $stable({line_out_plus, line_out_minus}) [*6])
      else $error("line symbol shorter than a bit period");
   // link clock and rail timing
   link_period_a: assert property ($rose(tx_line_clock) |=>
      tx_line_clock [*3] ##1 !tx_line_clock)
      else $error("link clock period wrong");
   rail_change_a: assert property ($changed(tx_positive_rail) |->
      !tx_line_clock)
      else $error("positive rail changed while link clock high");
   rail_setup_a: assert property ($rose(tx_line_clock) |->
      $stable(tx_negative_rail))
      else $error("negative rail moved at link clock rise");
endmodule
`default_nettype wire

// ### verif/line_tx_input_and_driver_test.sv
`timescale 1ns/1ps
`default_nettype none
module line_tx_input_and_driver_test;
   import ltx_pkg::*;
   logic clk_i = 0;
   logic rst_b_i = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd, w;
   logic pready, pslverr, perr, strobe, inv, act;
   logic dual = 0;
   logic e3 = 0;
   logic chan_on = 1;
   int bad_count = 0;
   int check_count = 0;
   int seed = 93161;
   int ninv = 0;
   int cnt = 0;
   logic [1:0] q[$];
   ltx_link_if link_if ();
   ltx_host ltx_host_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_if),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr));
   ltx_device ltx_device_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .link(link_if), .dual_rail_i(dual), .rate_e3_i(e3),
      .chan_tx_on_i(chan_on), .bit_strobe_o(strobe),
      .invalid_pair_o(inv), .line_active_o(act));
   ltx_link_properties ltx_link_properties_inst (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .tx_line_clock(link_if.tx_line_clock),
      .tx_positive_rail(link_if.tx_positive_rail),
      .tx_negative_rail(link_if.tx_negative_rail),
      .transmitter_on_control(link_if.transmitter_on_control),
      .line_out_plus(link_if.line_out_plus),
      .line_out_plus_oe(link_if.line_out_plus_oe),
      .line_out_minus(link_if.line_out_minus),
      .line_out_minus_oe(link_if.line_out_minus_oe));
   // clock
   initial forever #10 clk_i = ~clk_i;
   // line sampled mid bit period, bad pairs counted
   always @(posedge clk_i) begin
      if (strobe === 1'b1) cnt <= 4;
      else if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 1)
         q.push_back({link_if.line_out_plus, link_if.line_out_minus});
      if (inv === 1'b1) ninv <= ninv + 1;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1;
      // only the watchdog ends a wait that never gets an answer
      do @(posedge clk_i); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic restart(input logic d, input logic e);
      @(posedge clk_i);
      rst_b_i <= 0;
      dual <= d;
      e3 <= e;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1;
      q.delete();
      ninv = 0;
   endtask
   task automatic send(input logic d, input logic e, input logic [31:0] x);
      int n;
      restart(d, e);
      apb(1, REG_CTRL, {30'h0, 1'b1, d});
      apb(1, REG_DATA, x);
      n = 0;
      do begin
         apb(0, REG_STATUS, 0);
         n++;
      end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 500);
      chk(rd[STAT_BUSY_BIT], 0);
      repeat (80) @(posedge clk_i);
   endtask
   // decode line symbols back to data, check substitutions
   task automatic single(input logic e, input logic [31:0] x);
      int run, k, z, last, lastv;
      logic b[$];
      send(0, e, x);
      run = e ? HDB3_RUN : B3ZS_RUN;
      // last 0 means no pulse seen yet
      last = 0;
      lastv = 0;
      z = 0;
      foreach (q[i]) begin
         int p;
         p = (q[i] == 2'b10) ? 1 : (q[i] == 2'b01) ? -1 : 0;
         z = (p == 0) ? z + 1 : 0;
         if (z == run && last != 0) chk(z, 0);
         b.push_back(p != 0);
         if (p != 0 && p == last) begin
            if (lastv != 0) chk(p, -lastv);
            lastv = p;
            for (int j = 1; j <= run; j++) b[b.size() - j] = 0;
         end
         if (p != 0) last = p;
      end
      k = 0;
      while (k < b.size() && !b[k]) k++;
      for (int n = 0; n < 32; n++) chk(b[k + n], x[n]);
      $display("single rail word %h done", x);
   endtask
   // expected line pair for one dual rail bit period
   function automatic logic [1:0] dual_pair(input logic p, input logic n);
      return {p & !n, n & !p};
   endfunction
   task automatic dual_word(input logic [31:0] x);
      int k, c;
      send(1, 0, x);
      k = 0;
      while (k < q.size() && q[k] == 2'b00) k++;
      c = 0;
      for (int n = 0; n < 16; n++) begin
         chk(q[k + n], dual_pair(x[n], x[n + 16]));
         c += x[n] & x[n + 16];
      end
      chk(ninv, c);
      $display("dual rail word %h done", x);
   endtask
   // watchdog, about five times the planned run
   initial begin
      #(CLK_PERIOD_NS * 20000);
      bad_count++;
      summarize;
   end
   initial begin
      restart(1, 0);
      chk(link_if.line_out_plus_oe, 1);
      apb(0, REG_CTRL, 0);
      chk(rd, CTRL_RESET);
      apb(0, 8'h0C, 0);
      chk(perr, 1);
      chk(rd, 0);
      chan_on <= 0;
      repeat (3) @(posedge clk_i);
      chk(link_if.line_out_plus_oe, 0);
      chk(act, 0);
      chan_on <= 1;
      apb(1, REG_CTRL, 32'h1);
      repeat (5) @(posedge clk_i);
      chk(link_if.line_out_minus_oe, 0);
      apb(1, REG_CTRL, 32'h3);
      repeat (5) @(posedge clk_i);
      chk(link_if.line_out_minus_oe, 1);
      $display("enable test done");
      single(0, 32'h0000_0001);
      single(1, 32'h0000_0001);
      dual_word(32'hFFFE_FFFF);
      repeat (3) begin
         w = $random(seed);
         single(0, w | 32'h1);
         single(1, w | 32'h1);
         dual_word((w | 32'h1) & 32'hFFFE_FFFF);
      end
      summarize;
   end
endmodule
`default_nettype wire
